// [hdl/rqi_requester.sv]
`timescale 1ns/10ps
module rqi_requester (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           sys_rst,
   // User command port
   input  wire logic                           cmd_valid,
   output logic                                cmd_ready,
   input  wire rqi_pkg::rqi_kind_e             cmd_kind,
   input  wire logic                           cmd_addr_mode,
   input  wire logic [127:0]                   cmd_descriptor,
   input  wire logic [rqi_pkg::LEN_W-1:0]      cmd_dwords,
   input  wire logic [rqi_pkg::BE_W-1:0]       cmd_first_mask,
   input  wire logic [rqi_pkg::BE_W-1:0]       cmd_final_mask,
   input  wire logic [rqi_pkg::OFF_W-1:0]      cmd_offset,
   input  wire logic [31:0]                    cmd_fill,
   // Requester request stream to the device
   output logic                                req_in_valid,
   input  wire logic                           req_in_ready,
   output logic [rqi_pkg::DATA_W-1:0]          req_in_data,
   output logic                                req_in_last,
   output logic [7:0]                          req_in_keep,
   output logic [rqi_pkg::SB_W-1:0]            req_in_sideband
);
   typedef enum logic [1:0] {RQI_IDLE, RQI_SEND} rqi_state_e;

   rqi_state_e                   state, next_state;
   logic [rqi_pkg::LEN_W-1:0]    left, next_left;
   logic [31:0]                  word, next_word;
   logic                         amode, next_amode;
   logic                         first_beat, next_first_beat;
   logic [rqi_pkg::DATA_W-1:0]   next_data;
   logic                         next_valid;
   logic                         next_last;
   logic [7:0]                   next_keep;
   logic [rqi_pkg::SB_W-1:0]     next_sb;
   logic                         next_cmd_ready;
   logic [3:0]                   kg_first;
   logic [3:0]                   kg_count;
   logic [7:0]                   kg_keep;
   logic [rqi_pkg::LEN_W-1:0]    pay_len;
   logic [3:0]                   lane0;
   logic [3:0]                   fit;
   logic                         fire;

   rqi_keep_gen u_keep (
      .first_lane (kg_first),
      .count      (kg_count),
      .keep       (kg_keep)
   );

   // Lanes free from lane0 up to lane 7 in one beat
   function automatic logic [3:0] lanes_room(input logic [3:0] start);
      return 4'(8) - start;
   endfunction : lanes_room

   assign fire = req_in_valid && req_in_ready;

   always_comb begin
      next_state      = state;
      next_left       = left;
      next_word       = word;
      next_amode      = amode;
      next_first_beat = first_beat;
      next_data       = req_in_data;
      next_valid      = req_in_valid;
      next_last       = req_in_last;
      next_keep       = req_in_keep;
      next_sb         = req_in_sideband;
      next_cmd_ready  = 1'b0;
      kg_first        = 4'h0;
      kg_count        = 4'h0;
      lane0           = 4'h0;
      fit             = 4'h0;
      pay_len         = cmd_dwords;
      unique case (state)
         RQI_IDLE: begin
            next_cmd_ready = 1'b1;
            if (cmd_valid && cmd_ready) begin
               next_cmd_ready = 1'b0;
               next_amode     = cmd_addr_mode;
               next_sb        = '0;
               // Masks ride the first beat only; messages send zeros
               if (cmd_kind != rqi_pkg::RQI_MESSAGE) begin
                  next_sb[rqi_pkg::SB_FIRST_LO +: 4] = cmd_first_mask;
                  next_sb[rqi_pkg::SB_FINAL_LO +: 4] = cmd_final_mask;
               end
               if (cmd_addr_mode && cmd_kind != rqi_pkg::RQI_MESSAGE) begin
                  next_sb[rqi_pkg::SB_OFFSET_LO +: 3] = cmd_offset;
               end // messages keep offset zero
               // Zero-length write still ships one dummy Dword
               if (cmd_kind == rqi_pkg::RQI_NP_NO_DATA) begin
                  pay_len = '0;
               end else if (cmd_dwords == '0) begin
                  pay_len = 11'h001;
               end
               next_data          = '0;
               next_data[127:0]   = cmd_descriptor;
               next_word          = cmd_fill;
               if (cmd_addr_mode || pay_len == '0) begin
                  // Descriptor alone in the beat; payload waits a beat
                  kg_count    = 4'(rqi_pkg::DESC_DW);
                  next_keep   = kg_keep;
                  next_left   = pay_len;
                  next_last   = (pay_len == '0);
               end else begin
                  fit = (pay_len > 11'h004) ? 4'h4 : pay_len[3:0];
                  for (int i = 4; i < 8; i++) begin
                     if (4'(i - 4) < fit) next_data[i*32 +: 32] = cmd_fill;
                  end
                  kg_count    = 4'(rqi_pkg::DESC_DW) + fit;
                  next_keep   = kg_keep;
                  next_left   = pay_len - 11'(fit);
                  next_last   = (pay_len == 11'(fit));
               end
               next_first_beat = 1'b1;
               next_valid      = 1'b1;
               next_state      = RQI_SEND;
            end
         end
         RQI_SEND: begin
            // Nothing changes until the beat is taken
            if (fire) begin
               if (req_in_last) begin
                  next_valid     = 1'b0;
                  next_last      = 1'b0;
                  next_keep      = '0;
                  next_sb        = '0;
                  next_state     = RQI_IDLE;
                  next_cmd_ready = 1'b1;
               end else begin
                  // Valid stays high into the next beat
                  lane0 = (amode && first_beat) ?
                          {1'b0, req_in_sideband[rqi_pkg::SB_OFFSET_LO +: 3]} : 4'h0;
                  fit   = (left > 11'(lanes_room(lane0))) ? lanes_room(lane0) : left[3:0];
                  // Null lanes ahead of the start lane still count as kept
                  kg_first = 4'h0;
                  kg_count = lane0 + fit;
                  next_keep = kg_keep;
                  next_data = '0;
                  for (int i = 0; i < 8; i++) begin
                     if (kg_keep[i] && 4'(i) >= lane0) next_data[i*32 +: 32] = word + 32'(i);
                  end
                  next_word       = word + 32'h00000008;
                  next_left       = left - 11'(fit);
                  next_last       = (left == 11'(fit));
                  next_first_beat = 1'b0;
                  next_sb[7:0]    = 8'h00;
               end
            end
         end
         default: next_state = RQI_IDLE;
      endcase
   end

   // Length limits are the command source's duty; the count field caps it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state           <= RQI_IDLE;
         left            <= '0;
         word            <= '0;
         amode           <= 1'b0;
         first_beat      <= 1'b0;
         req_in_data     <= '0;
         req_in_valid    <= 1'b0;
         req_in_last     <= 1'b0;
         req_in_keep     <= '0;
         req_in_sideband <= '0;
         cmd_ready       <= 1'b0;
      end else begin
         state           <= next_state;
         left            <= next_left;
         word            <= next_word;
         amode           <= next_amode;
         first_beat      <= next_first_beat;
         req_in_data     <= next_data;
         req_in_valid    <= next_valid;
         req_in_last     <= next_last;
         req_in_keep     <= next_keep;
         req_in_sideband <= next_sb;
         cmd_ready       <= next_cmd_ready;
      end
   end
endmodule : rqi_requester

// [hdl/rqi_pkg.sv]
package rqi_pkg;
   // Datapath: 256 bits, eight Dword lanes
   localparam int DATA_W    = 256;
   localparam int LANES     = 8;
   localparam int DW_W      = 32;
   localparam int DESC_DW   = 4;
   localparam int LEN_W     = 11;
   // Sideband layout
   localparam int SB_W          = 60;
   localparam int SB_FIRST_LO   = 0;
   localparam int SB_FINAL_LO   = 4;
   localparam int SB_OFFSET_LO  = 8;
   localparam int BE_W          = 4;
   localparam int OFF_W         = 3;
   localparam logic [3:0] BE_NONE = 4'h0;
   localparam logic [3:0] BE_ALL  = 4'hF;
   // Request kinds issued by the user port
   typedef enum logic [1:0] {
      RQI_MEM_WRITE,
      RQI_NP_NO_DATA,
      RQI_NP_DATA,
      RQI_MESSAGE
   } rqi_kind_e;
endpackage : rqi_pkg

// [hdl/rqi_keep_gen.sv]
`timescale 1ns/10ps
module rqi_keep_gen (
   // Lane window
   input  wire logic [3:0] first_lane,
   input  wire logic [3:0] count,
   // Contiguous keep vector
   output logic [7:0]      keep
);
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         keep[i] = (4'(i) >= first_lane) && (4'(i) < first_lane + count);
      end
   end
endmodule : rqi_keep_gen

// [verif/rqi_requester_props.sv]
`timescale 1ns/10ps
module rqi_requester_props (
   // Clock and command side
   input wire logic                clk,
   input wire logic                sys_rst,
   input wire logic                cmd_valid,
   input wire logic                cmd_ready,
   input wire rqi_pkg::rqi_kind_e  cmd_kind,
   input wire logic                cmd_addr_mode,
   input wire logic [10:0]         cmd_dwords,
   input wire logic [3:0]          cmd_first_mask,
   input wire logic [3:0]          cmd_final_mask,
   // Stream side
   input wire logic                req_in_valid,
   input wire logic                req_in_ready,
   input wire logic [255:0]        req_in_data,
   input wire logic                req_in_last,
   input wire logic [7:0]          req_in_keep,
   input wire logic [59:0]         req_in_sideband
);
   // High while the descriptor beat of a packet is still on offer
   logic pkt_head;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pkt_head <= 1'b0;
      end else if (cmd_valid && cmd_ready) begin
         pkt_head <= 1'b1;
      end else if (req_in_valid && req_in_ready) begin
         pkt_head <= 1'b0;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_stall_hold: assert property (req_in_valid && !req_in_ready |=> req_in_valid &&
      $stable(req_in_data) && $stable(req_in_keep) && $stable(req_in_last)) else $error("stall moved");
   a_valid_run: assert property (req_in_valid && !req_in_last |=> req_in_valid)
      else $error("valid gap");
   a_end_drop: assert property (req_in_valid && req_in_ready && req_in_last |=> !req_in_valid && cmd_ready)
      else $error("no idle after last");
   a_keep_shape: assert property (req_in_valid |-> req_in_keep[0] && ((req_in_keep + 8'h01) & req_in_keep) == 8'h00)
      else $error("keep gap");
   a_keep_full: assert property (req_in_valid && !req_in_last |-> req_in_keep == 8'hFF ||
      (pkt_head && req_in_keep == 8'h0F)) else $error("short mid beat");
   a_cmd_answer: assert property (cmd_valid && cmd_ready |=> req_in_valid && !cmd_ready)
      else $error("no beat after command");
   a_no_data: assert property (cmd_valid && cmd_ready && cmd_kind == rqi_pkg::RQI_NP_NO_DATA
      |=> req_in_last && req_in_keep == 8'h0F) else $error("bad read beat");
   a_masks_first: assert property (cmd_valid && cmd_ready && cmd_kind != rqi_pkg::RQI_MESSAGE
      |=> req_in_sideband[7:0] == {$past(cmd_final_mask), $past(cmd_first_mask)}) else $error("masks");
   a_msg_lane: assert property (cmd_valid && cmd_ready && cmd_kind == rqi_pkg::RQI_MESSAGE && cmd_addr_mode
      |=> req_in_sideband[10:8] == 3'h0) else $error("message lane");
   a_short_write: assert property (cmd_valid && cmd_ready && cmd_kind == rqi_pkg::RQI_MEM_WRITE &&
      !cmd_addr_mode && cmd_dwords == 11'h002 |=> req_in_keep == 8'h3F && req_in_last) else $error("short write");
   c_stall: cover property (req_in_valid && !req_in_ready);
   c_multi: cover property (req_in_valid && req_in_ready && !req_in_last);
   c_msg: cover property (cmd_valid && cmd_ready && cmd_kind == rqi_pkg::RQI_MESSAGE);
endmodule : rqi_requester_props
bind rqi_requester rqi_requester_props u_props (.clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd_kind,
   .cmd_addr_mode, .cmd_dwords, .cmd_first_mask, .cmd_final_mask, .req_in_valid, .req_in_ready,
   .req_in_data, .req_in_last, .req_in_keep, .req_in_sideband);

// [verif/rqi_dev_model.sv]
`timescale 1ns/10ps
module rqi_dev_model (
   // Clock and stream
   input wire logic  clk,
   input wire logic  sys_rst,
   input wire logic  req_in_valid,
   input wire logic  req_in_last,
   output logic      req_in_ready,
   // Stall control and counts
   input wire logic  slow,
   output int        pkts,
   output int        nulls
);
   logic in_pkt;
   logic ph;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {in_pkt, ph, req_in_ready} <= 3'h0;
         pkts <= 0;
         nulls <= 0;
      end else begin
         ph <= !ph;
         req_in_ready <= !(slow && ph);
         if (req_in_valid && req_in_ready) begin
            in_pkt <= !req_in_last;
            pkts <= pkts + (req_in_last ? 1 : 0);
         end
         if (in_pkt && !req_in_valid) begin
            nulls <= nulls + 1;
            in_pkt <= 1'b0;
         end
      end
   end
endmodule : rqi_dev_model

// [verif/rqi_requester_tb_top.sv]
`timescale 1ns/10ps
module rqi_requester_tb_top;
   logic clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, cmd_addr_mode = 1'b0, slow = 1'b0;
   logic cmd_ready, req_in_valid, req_in_ready, req_in_last;
   rqi_pkg::rqi_kind_e cmd_kind = rqi_pkg::RQI_MEM_WRITE;
   logic [127:0] cmd_descriptor = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
   logic [10:0]  cmd_dwords = 11'h000;
   logic [3:0]   cmd_first_mask = 4'h0, cmd_final_mask = 4'h0;
   logic [2:0]   cmd_offset = 3'h0;
   logic [31:0]  cmd_fill = 32'hA5A5_0000;
   logic [255:0] req_in_data;
   logic [7:0]   req_in_keep;
   logic [59:0]  req_in_sideband;
   int           n_mismatch = 0, checks_done = 0, pkts, nulls;
   always #5 clk = ~clk;
   rqi_requester dut (.clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd_kind, .cmd_addr_mode,
      .cmd_descriptor, .cmd_dwords, .cmd_first_mask, .cmd_final_mask, .cmd_offset, .cmd_fill,
      .req_in_valid, .req_in_ready, .req_in_data, .req_in_last, .req_in_keep, .req_in_sideband);
   rqi_dev_model dev (.clk, .sys_rst, .req_in_valid, .req_in_last, .req_in_ready, .slow, .pkts,
      .nulls);
   task chk(input logic [255:0] got, input logic [255:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask : chk
   task final_report;
      $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   // Offer one command, then judge every accepted beat of its packet
   task pkt(input rqi_pkg::rqi_kind_e kd, input logic md, input logic [10:0] dw,
      input logic [3:0] fm, input logic [3:0] lm, input logic [2:0] off, input logic [2:0] eoff,
      input logic [7:0] ek[$]);
      int n;
      int t;
      n = 0;
      t = 0;
      @(negedge clk);
      cmd_kind = kd;
      {cmd_addr_mode, cmd_dwords, cmd_first_mask, cmd_final_mask, cmd_offset} = {md, dw, fm, lm, off};
      cmd_valid = 1'b1;
      while (!cmd_ready && t < 100) begin
         @(negedge clk);
         t++;
      end
      @(negedge clk);
      cmd_valid = 1'b0;
      // Judged at the falling edge: the beat standing here is taken at the next rise
      while (n < ek.size() && t < 200) begin
         if (req_in_valid && req_in_ready) begin
            if (n == 0) begin
               chk(req_in_data[127:0], cmd_descriptor, "descriptor");
               chk(req_in_sideband[10:0], {eoff, lm, fm}, "sideband");
            end
            chk(req_in_keep, ek[n], "keep");
            chk(req_in_last, n == ek.size() - 1, "last");
            n++;
         end
         if (n < ek.size()) begin
            @(negedge clk);
            t++;
         end
      end
      if (n < ek.size()) begin
         n_mismatch++;
         final_report();
      end
   endtask : pkt
   task s_dword;
      pkt(rqi_pkg::RQI_MEM_WRITE, 1'b0, 11'h002, 4'h5, 4'hA, 3'h0, 3'h0, '{8'h3F});
      @(negedge clk);
      slow = 1'b1;
      pkt(rqi_pkg::RQI_MEM_WRITE, 1'b0, 11'h00D, 4'hF, 4'hF, 3'h0, 3'h0, '{8'hFF, 8'hFF, 8'h01});
      @(negedge clk);
      slow = 1'b0;
      pkt(rqi_pkg::RQI_NP_DATA, 1'b0, 11'h001, 4'h3, 4'h0, 3'h0, 3'h0, '{8'h1F});
   endtask : s_dword
   task s_addr;
      pkt(rqi_pkg::RQI_MEM_WRITE, 1'b1, 11'h004, 4'hF, 4'h3, 3'h5, 3'h5, '{8'h0F, 8'hFF, 8'h01});
      pkt(rqi_pkg::RQI_NP_NO_DATA, 1'b1, 11'h001, 4'h0, 4'h0, 3'h6, 3'h6, '{8'h0F});
      pkt(rqi_pkg::RQI_MESSAGE, 1'b1, 11'h002, 4'h0, 4'h0, 3'h3, 3'h0, '{8'h0F, 8'h03});
   endtask : s_addr
   task s_zero;
      pkt(rqi_pkg::RQI_MEM_WRITE, 1'b0, 11'h000, 4'h0, 4'h0, 3'h0, 3'h0, '{8'h1F});
      pkt(rqi_pkg::RQI_NP_NO_DATA, 1'b0, 11'h001, 4'hF, 4'hF, 3'h0, 3'h0, '{8'h0F});
   endtask : s_zero
   initial begin
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge clk);
      s_dword();
      s_addr();
      s_zero();
      repeat (2) @(negedge clk);
      chk(pkts, 8, "packets");
      chk(nulls, 0, "nullified");
      final_report();
   end
endmodule : rqi_requester_tb_top
